// file: hw/sec_eeprom_core.sv
// command and sequencing logic of a small spi serial eeprom
// assumes spi pins arrive asynchronously; sck is sampled by clk_sys
//
// Functional notes
// - page write accepts up to 32 bytes
// - only byte-in-page address bits increment
// - page overflow wraps to page start
// - programming end clears write enable latch
// - address is 16 bits, upper ignored
// - status write changes bits 2,3,7 only
// - guard pin low plus enable blocks status write
// - guard pin falling aborts pending status write
// - started status programming ignores guard pin
// - enable bit zero ignores guard pin
// - read data follows last address bit
// - read address increments, wraps at top
// - select high ends read, output off
// - status read shifts eight status bits
// - status read allowed while busy
// - pause floats output, ignores input
// - power-up leaves write latch cleared
// - programming starts on select rise, whole bytes
// - array commands ignored while busy
// - unknown opcode ignored, output stays off
// - six opcodes are recognised
// - status byte layout with busy flag
// - block guard bits protect upper region
// - writes need write enable latch set
`timescale 1ns/1ps
module sec_eeprom_core
  import sec_pkg::*;
#(
  parameter int AW          = 11,          // 10 for 8 Kb, 11 for 16 Kb
  parameter int PROG_CYC    = PROG_CYCLES  // programming duration in clk_sys cycles
) (
  input  wire logic clk_sys,   // system clock
  input  wire logic rst_n,     // synchronous reset, power-on
  input  wire logic selectN,   // chip select pin, active low
  input  wire logic sck,       // serial clock pin
  input  wire logic sdi,       // serial data in pin
  input  wire logic guardN,    // write guard pin, active low
  input  wire logic pauseN,    // pause pin, active low
  output logic      sdo,       // serial data out
  output logic      sdoOe,     // serial out enable, high drives
  output logic      busyOut,   // programming in progress
  output logic [7:0] statusOut // status byte view
);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int DEPTH = 1 << AW;
  if (AW < 10 || AW > 11) begin : gBadAw
    $error("AW must be 10 or 11");
  end
  if (PROG_CYC < 2) begin : gBadProg
    $error("PROG_CYC must be at least 2");
  end
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pinSync;
  // sck starts at its mode 0 idle level so no false edge follows reset
  sec_sync #(.WIDTH(5), .INIT(5'h13)) uSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({selectN, sck, sdi, guardN, pauseN}),
    .syncOut (pinSync)
  );
  logic selS, sckS, sdiS, guardS, pauseS;
  assign {selS, sckS, sdiS, guardS, pauseS} = pinSync;
  logic sckPrevReg, selPrevReg, guardPrevReg, pausedReg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sckPrevReg   <= 1'b0;
      selPrevReg   <= 1'b1;
      guardPrevReg <= 1'b1;
      pausedReg    <= 1'b0;
    end else begin
      sckPrevReg   <= sckS;
      selPrevReg   <= selS;
      guardPrevReg <= guardS;
      if (!sckS) pausedReg <= !pauseS && !selS;
    end
  end
  logic active, sckRise, sckFall, selRise, guardFall;
  assign active    = !selS && !pausedReg;
  assign sckRise   = active && sckS && !sckPrevReg;
  assign sckFall   = active && !sckS && sckPrevReg;
  assign selRise   = selS && !selPrevReg;
  assign guardFall = !guardS && guardPrevReg;
  // ---------------------------------------------------------------
  // storage, status and programming timer
  // ---------------------------------------------------------------
  logic [7:0] memReg [DEPTH];
  logic [7:0] pageReg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageValidReg;
  logic [7:0] statusReg;
  logic progStart, progBusy, progDone;
  sec_prog_timer #(.CYCLES(PROG_CYC)) uTimer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (progStart),
    .busy    (progBusy),
    .done    (progDone)
  );
  // ---------------------------------------------------------------
  // frame decoding
  // ---------------------------------------------------------------
  sec_phase_t phaseReg;
  logic [4:0]  bitCntReg;
  logic [15:0] shiftReg;
  logic [7:0]  opReg;
  logic [AW-1:0] addrReg;
  logic [PW-1:0] pageOffReg;
  logic [7:0]  outShiftReg;
  logic [7:0]  stNewReg;
  logic        wholeByteReg, gotDataReg, wrPendReg, stPendReg, stAbortReg;
  logic        progIsStatusReg;
  logic [AW-1:0] progBaseReg;
  logic [7:0]  shiftIn;
  assign shiftIn = {shiftReg[6:0], sdiS};
  function automatic logic isProtected(input logic [AW-1:0] a, input logic [1:0] bg);
    unique case (bg)
      2'b00:   isProtected = 1'b0;
      2'b01:   isProtected = (a[AW-1:AW-2] == 2'b11);
      2'b10:   isProtected = a[AW-1];
      default: isProtected = 1'b1;
    endcase
  endfunction
  logic stBlocked;
  assign stBlocked = statusReg[ST_PPE] && !guardS;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phaseReg     <= PH_OPCODE;
      bitCntReg    <= '0;
      shiftReg     <= '0;
      opReg        <= '0;
      addrReg      <= '0;
      pageOffReg   <= '0;
      outShiftReg  <= FILL_BYTE;
      stNewReg     <= '0;
      wholeByteReg <= 1'b1;
      gotDataReg   <= 1'b0;
      wrPendReg    <= 1'b0;
      stPendReg    <= 1'b0;
      stAbortReg   <= 1'b0;
    end else if (selS) begin
      phaseReg     <= PH_OPCODE;
      bitCntReg    <= '0;
      wholeByteReg <= 1'b1;
      gotDataReg   <= 1'b0;
      stAbortReg   <= 1'b0;
    end else begin
      if (phaseReg == PH_STWRITE && guardFall && statusReg[ST_PPE])
        stAbortReg <= 1'b1;
      if (sckRise) begin
        shiftReg  <= {shiftReg[14:0], sdiS};
        bitCntReg <= bitCntReg + 5'd1;
        wholeByteReg <= (bitCntReg[2:0] == 3'd7);
        unique case (phaseReg)
          PH_OPCODE: if (bitCntReg == 5'(OPCODE_BITS - 1)) begin
            bitCntReg <= '0;
            opReg     <= shiftIn;
            unique case (shiftIn)
              OP_WRITE_ENABLE, OP_WRITE_DISABLE: phaseReg <= PH_DONE;
              OP_STATUS_READ: begin
                phaseReg    <= PH_STREAD;
                outShiftReg <= {statusReg[7:1], progBusy};
              end
              OP_STATUS_WRITE: phaseReg <= progBusy ? PH_IGNORE : PH_STWRITE;
              OP_READ, OP_WRITE: phaseReg <= progBusy ? PH_IGNORE : PH_ADDR;
              default: phaseReg <= PH_IGNORE;
            endcase
          end
          PH_ADDR: if (bitCntReg == 5'(ADDR_BITS - 1)) begin
            bitCntReg <= '0;
            addrReg   <= AW'({shiftReg[14:0], sdiS});
            if (opReg == OP_READ) begin
              phaseReg    <= PH_RDATA;
              outShiftReg <= memReg[AW'({shiftReg[14:0], sdiS})];
            end else begin
              phaseReg   <= PH_WDATA;
              pageOffReg <= PW'(shiftIn);
            end
          end
          PH_WDATA: if (bitCntReg[2:0] == 3'd7) begin
            gotDataReg <= 1'b1;
            pageOffReg <= pageOffReg + 1'b1;
          end
          // count parks in 8..15 so a long read never falls back to the first-byte state
          PH_RDATA: if (bitCntReg[2:0] == 3'd7) begin
            addrReg   <= addrReg + 1'b1;
            bitCntReg <= 5'd8;
          end
          PH_STREAD: if (bitCntReg[2:0] == 3'd7) begin
            bitCntReg <= 5'd8;
          end
          PH_STWRITE: if (bitCntReg[2:0] == 3'd7) begin
            gotDataReg <= 1'b1;
            stNewReg   <= shiftIn;
          end
          default: ;
        endcase
      end
      if (sckFall) begin
        if (phaseReg == PH_RDATA && bitCntReg[2:0] == 3'd0 && bitCntReg != 5'd0)
          outShiftReg <= memReg[addrReg];
        else if (phaseReg == PH_STREAD && bitCntReg[2:0] == 3'd0 && bitCntReg != 5'd0)
          outShiftReg <= {statusReg[7:1], progBusy};
        // the first fall after the last command bit keeps the msb on the line
        else if (bitCntReg != 5'd0)
          outShiftReg <= {outShiftReg[6:0], 1'b1};
      end
    end
  end
  // ---------------------------------------------------------------
  // page buffer loading
  // ---------------------------------------------------------------
  logic pageLoad;
  assign pageLoad = !selS && sckRise && phaseReg == PH_WDATA && bitCntReg[2:0] == 3'd7;
  generate
    for (genvar g = 0; g < PAGE_BYTES; g++) begin : gPage
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          pageReg[g]      <= '0;
          pageValidReg[g] <= 1'b0;
        end else if (phaseReg == PH_ADDR && sckRise) begin
          pageValidReg[g] <= 1'b0;
        end else if (pageLoad && pageOffReg == PW'(g)) begin
          pageReg[g]      <= shiftIn;
          pageValidReg[g] <= 1'b1;
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // commit on select rise, programming and status
  // ---------------------------------------------------------------
  logic frameEnd, wrOk, stOk;
  assign frameEnd = selRise && wholeByteReg && gotDataReg;
  assign wrOk = frameEnd && phaseReg == PH_WDATA && statusReg[ST_WEL]
              && !isProtected(addrReg, statusReg[ST_BG1:ST_BG0]);
  assign stOk = frameEnd && phaseReg == PH_STWRITE && statusReg[ST_WEL]
              && !stBlocked && !stAbortReg;
  assign progStart = wrOk || stOk;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      statusReg       <= ST_RESET_VALUE;
      progIsStatusReg <= 1'b0;
      progBaseReg     <= '0;
    end else begin
      if (stOk) begin
        progIsStatusReg <= 1'b1;
        progBaseReg     <= addrReg;
        // status bits change only when the cycle ends; guard pin no longer looked at
      end else if (wrOk) begin
        progIsStatusReg <= 1'b0;
        progBaseReg     <= addrReg;
      end
      if (progDone) begin
        statusReg[ST_WEL] <= 1'b0;
        if (progIsStatusReg)
          statusReg <= ((statusReg & ~ST_WRITABLE_MASK) | (stNewReg & ST_WRITABLE_MASK))
                       & 8'hFD;
      end
      // latch commands follow the end-of-cycle clear, so a set in the same cycle wins
      if (selRise && wholeByteReg && phaseReg == PH_DONE && opReg == OP_WRITE_ENABLE
          && !progBusy)
        statusReg[ST_WEL] <= 1'b1;
      if (selRise && wholeByteReg && phaseReg == PH_DONE && opReg == OP_WRITE_DISABLE
          && !progBusy)
        statusReg[ST_WEL] <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (progDone && !progIsStatusReg) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageValidReg[i])
          memReg[{progBaseReg[AW-1:PW], PW'(i)}] <= pageReg[i];
      end
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sdo       <= 1'b1;
      sdoOe     <= 1'b0;
      busyOut   <= 1'b0;
      statusOut <= ST_RESET_VALUE;
    end else begin
      sdo       <= outShiftReg[7];
      sdoOe     <= active && (phaseReg == PH_RDATA || phaseReg == PH_STREAD);
      busyOut   <= progBusy;
      statusOut <= {statusReg[7:1], progBusy};
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_SEL_HIGH_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    selS |=> !sdoOe) else $error("output enabled while deselected");
  AST_WEL_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    progDone |=> !statusReg[ST_WEL]) else $error("latch kept after programming");
  AST_BUSY_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(progBusy) |-> progBusy [*8]) else $error("busy too short");
  AST_NO_START_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    progBusy && sckRise && phaseReg == PH_OPCODE && bitCntReg == 5'd7
    && (shiftIn == OP_READ || shiftIn == OP_WRITE) |=> phaseReg == PH_IGNORE)
    else $error("array command taken while busy");
  AST_IGNORE_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phaseReg == PH_IGNORE |=> !sdoOe) else $error("output on for bad opcode");
  AST_STW_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stBlocked |-> !stOk) else $error("status write under guard");
  AST_PAUSE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pausedReg |=> !sdoOe) else $error("output on while paused");
  AST_STATUS_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    progDone && progIsStatusReg |=> statusReg[6:4] == 3'b000)
    else $error("reserved status bits changed");
endmodule

// file: hw/sec_pkg.sv
// package of constants for the serial eeprom command logic
// assumes a single 100 MHz system clock domain
package sec_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE         = 8'h02;
  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_BG0  = 2;
  localparam int ST_BG1  = 3;
  localparam int ST_PPE  = 7;
  localparam logic [7:0] ST_WRITABLE_MASK = 8'h8C;
  localparam logic [7:0] ST_RESET_VALUE   = 8'h00;
  // ---------------------------------------------------------------
  // framing and timing
  // ---------------------------------------------------------------
  localparam int OPCODE_BITS  = 8;
  localparam int ADDR_BITS    = 16;
  localparam int PAGE_BYTES   = 32;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_US  = 5;
  localparam int PROG_CYCLES   = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  typedef enum logic [2:0] {
    PH_OPCODE  = 3'b000,
    PH_ADDR    = 3'b001,
    PH_WDATA   = 3'b010,
    PH_RDATA   = 3'b011,
    PH_STREAD  = 3'b100,
    PH_STWRITE = 3'b101,
    PH_DONE    = 3'b110,
    PH_IGNORE  = 3'b111
  } sec_phase_t;
endpackage

// file: hw/sec_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module sec_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rst_n,    // synchronous reset
  input  wire logic [WIDTH-1:0] pinIn,    // raw pins
  output logic      [WIDTH-1:0] syncOut   // synchronised levels
);
  // only the second stage is visible; stage1Reg may be metastable
  logic [WIDTH-1:0] stage1Reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1Reg <= INIT;
      syncOut   <= INIT;
    end else begin
      stage1Reg <= pinIn;
      syncOut   <= stage1Reg;
    end
  end
endmodule

// file: hw/sec_prog_timer.sv
// self-timed programming cycle counter
// assumes a one-cycle start pulse from the command logic
`timescale 1ns/1ps
module sec_prog_timer #(
  parameter int CYCLES = 500
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst_n,    // synchronous reset
  input  wire logic start,    // start pulse
  output logic      busy,     // cycle running
  output logic      done      // one-cycle end pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cntReg;
  if (CYCLES < 2) begin : gBadCycles
    $error("CYCLES must be at least 2");
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cntReg <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cntReg <= CW'(CYCLES - 1);
        busy   <= 1'b1;
      end else if (busy) begin
        if (cntReg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cntReg <= cntReg - 1'b1;
        end
      end
    end
  end
endmodule

// file: tb/sec_host_model.sv
// spi host model for the eeprom pins, mode 0
// assumes the bench calls its tasks; sck stands still outside frames
`timescale 1ns/1ps
module sec_host_model (
  input  wire logic clk_sys,  // frame alignment only
  output logic      selectN,  // chip select, active low
  output logic      sck,      // serial clock, 125 ns period
  output logic      sdi,      // serial data to device
  output logic      pauseN,   // pause request, active low
  input  wire logic sdoWire   // resolved serial out line
);
  initial begin
    selectN = 1'b1;
    sck     = 1'b0;
    sdi     = 1'b0;
    pauseN  = 1'b1;
  end
  // ----
  // frame tasks
  // ----
  // odd start offset keeps sck edges clear of both clk_sys edges
  task automatic open_frame();
    @(negedge clk_sys);
    selectN = 1'b0;
    #201.25;
  endtask
  // opcodes, 16-bit addresses and data go as whole bytes, msb first
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      sdi = tx[b];
      #62.5 sck = 1'b1;
      rx[b] = sdoWire;
      #62.5 sck = 1'b0;
    end
  endtask
  // select rises only after whole bytes, also ending a read
  task automatic close_frame();
    #200;
    @(negedge clk_sys);
    selectN = 1'b1;
    sdi     = ~sdi;
    repeat (10) @(negedge clk_sys);
  endtask
  // pause entered and left with sck low, select held low
  task automatic hold_on();
    // step off the sck fall so the pause clearly starts with sck low
    #20 pauseN = 1'b0;
    repeat (6) #20 sdi = ~sdi;
  endtask
  task automatic hold_off();
    pauseN = 1'b1;
    #100;
  endtask
endmodule

// file: tb/sec_eeprom_core_tb.sv
// self-checking bench for the eeprom command logic
// assumes sec_host_model drives the pins; output line has no pull
`timescale 1ns/1ps
module sec_eeprom_core_tb;
  import sec_pkg::*;
  localparam int PCYC = 1500;
  logic       clk_sys;
  logic       rst_n;
  logic       guardN;
  logic       selectN;
  logic       sck;
  logic       sdi;
  logic       pauseN;
  logic       sdo;
  logic       sdoOe;
  logic       busyOut;
  logic [7:0] statusOut;
  logic [7:0] rxb;
  logic       sdoLast = 1'b0;
  logic       oeSeen  = 1'b0;
  logic [7:0] mem [0:2047];
  int         badCount = 0;
  int         nTests   = 0;
  // released line shows the inverse of its last driven value
  wire logic  sdoWire = sdoOe ? sdo : ~sdoLast;

  sec_eeprom_core #(.AW(11), .PROG_CYC(PCYC)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .selectN(selectN), .sck(sck), .sdi(sdi),
    .guardN(guardN), .pauseN(pauseN), .sdo(sdo), .sdoOe(sdoOe),
    .busyOut(busyOut), .statusOut(statusOut));
  sec_host_model host_u (.clk_sys(clk_sys), .selectN(selectN), .sck(sck), .sdi(sdi),
    .pauseN(pauseN), .sdoWire(sdoWire));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (sdoOe) begin
      sdoLast <= sdo;
      oeSeen  <= 1'b1;
    end
  end
  // ----
  // compare and access tasks
  // ----
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic closeOut();
    $display("counts: %0d checks, %0d mismatches", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.open_frame();
    host_u.xbyte(op, rxb);
    host_u.close_frame();
  endtask
  task automatic statusRead();
    host_u.open_frame();
    host_u.xbyte(OP_STATUS_READ, rxb);
    host_u.xbyte(8'h00, rxb);
    host_u.close_frame();
  endtask
  task automatic sendAddr(input logic [7:0] op, input logic [15:0] a);
    host_u.open_frame();
    host_u.xbyte(op, rxb);
    host_u.xbyte(a[15:8], rxb);
    host_u.xbyte(a[7:0], rxb);
  endtask
  task automatic waitIdle();
    int n = 0;
    while (busyOut !== 1'b0 && n < PCYC + 200) begin
      @(negedge clk_sys);
      n++;
    end
    // status and array settle one cycle after busy drops
    repeat (2) @(negedge clk_sys);
    checkBit("busy end", 1'b0, busyOut);
  endtask
  task automatic wrByte(input logic [15:0] a, input logic [7:0] d, input logic ok);
    cmd(OP_WRITE_ENABLE);
    sendAddr(OP_WRITE, a);
    host_u.xbyte(d, rxb);
    host_u.close_frame();
    checkBit("busy after write", ok, busyOut);
    if (ok) begin
      mem[a[10:0]] = d;
      waitIdle();
    end
  endtask
  task automatic status_write_cmd(input logic [7:0] d, input logic dropGuard);
    cmd(OP_WRITE_ENABLE);
    host_u.open_frame();
    host_u.xbyte(OP_STATUS_WRITE, rxb);
    // a short low pulse: only the in-frame abort can stop this write
    if (dropGuard) begin
      #40 guardN = 1'b0;
      #100 guardN = 1'b1;
      #40;
    end
    host_u.xbyte(d, rxb);
    host_u.close_frame();
  endtask
  // reads n bytes, optionally pausing right after the address
  task automatic readCheck(input logic [15:0] a, input int n, input logic doPause);
    sendAddr(OP_READ, a);
    if (doPause) begin
      host_u.hold_on();
      checkBit("out during pause", 1'b0, sdoOe);
      host_u.hold_off();
    end
    for (int i = 0; i < n; i++) begin
      host_u.xbyte(8'h00, rxb);
      check8("read byte", mem[a[10:0] + 11'(i)], rxb);
    end
    host_u.close_frame();
    checkBit("out after select high", 1'b0, sdoOe);
  endtask
  // ----
  // tests
  // ----
  initial begin
    rst_n  = 1'b0;
    guardN = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check8("status after reset", ST_RESET_VALUE, statusOut);
    statusRead();
    check8("status read idle", 8'h00, rxb);
    cmd(OP_WRITE_ENABLE);
    checkBit("latch set", 1'b1, statusOut[ST_WEL]);
    cmd(OP_WRITE_DISABLE);
    checkBit("latch cleared", 1'b0, statusOut[ST_WEL]);
    sendAddr(OP_WRITE, 16'h0000);
    host_u.xbyte(8'h55, rxb);
    host_u.close_frame();
    checkBit("write without latch", 1'b0, busyOut);
    $display("test latch done");
    // 33 bytes from offset 30: the last one lands on offset 30 again
    cmd(OP_WRITE_ENABLE);
    sendAddr(OP_WRITE, 16'h003E);
    for (int i = 0; i < 33; i++) begin
      host_u.xbyte(8'h40 + 8'(i), rxb);
      mem[11'h020 + 11'((30 + i) % 32)] = 8'h40 + 8'(i);
    end
    host_u.close_frame();
    checkBit("busy after page", 1'b1, busyOut);
    statusRead();
    check8("status while busy", 8'h03, rxb);
    oeSeen = 1'b0;
    readCheck(16'h0020, 0, 1'b0);
    checkBit("read while busy", 1'b0, oeSeen);
    waitIdle();
    checkBit("latch after program", 1'b0, statusOut[ST_WEL]);
    readCheck(16'hF820, 32, 1'b0);
    $display("test page done");
    wrByte(16'h07FF, 8'hA5, 1'b1);
    wrByte(16'h0000, 8'h5A, 1'b1);
    readCheck(16'h07FF, 2, 1'b1);
    $display("test wrap done");
    status_write_cmd(8'hFF, 1'b0);
    waitIdle();
    check8("status write mask", 8'h8C, statusOut);
    wrByte(16'h0100, 8'h33, 1'b0);
    guardN = 1'b0;
    status_write_cmd(8'h00, 1'b0);
    checkBit("guarded status write", 1'b0, busyOut);
    check8("guarded status", 8'h8C, statusOut & 8'hFC);
    guardN = 1'b1;
    status_write_cmd(8'h00, 1'b1);
    checkBit("guard fall in frame", 1'b0, busyOut);
    check8("aborted status", 8'h8C, statusOut & 8'hFC);
    guardN = 1'b1;
    status_write_cmd(8'h00, 1'b0);
    guardN = 1'b0;
    waitIdle();
    check8("guard fall after start", 8'h00, statusOut);
    status_write_cmd(8'h04, 1'b0);
    waitIdle();
    check8("guard ignored", 8'h04, statusOut);
    wrByte(16'h0600, 8'h11, 1'b0);
    wrByte(16'h05FF, 8'h22, 1'b1);
    $display("test status done");
    oeSeen = 1'b0;
    sendAddr(8'hAB, 16'h0000);
    host_u.close_frame();
    checkBit("unknown opcode output", 1'b0, oeSeen);
    $display("test opcode done");
    closeOut();
  end
  // the tests need about 250 us; 600 us leaves room within the cycle budget
  initial begin
    #600000;
    badCount++;
    $display("watchdog expired");
    closeOut();
  end
endmodule
